// ---- rtl/ppc_port_ctrl.sv ----
// Function
// - Oscillator pins pulled down during reset.
// - Reset pin as port ignores reset.
// - Nonvolatile byte selects reset pin function.
// - Low reset pin before fetch holds reset.
// - Output change on irq pins sets flag.
// - Analog mode bit disables digital port; the port 2 irq edge detector and the port 2 pull-ups are not gated by it.
// - Bit operation is full-port read-modify-write.
// - Input pin latch takes pin level back.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ppc_port_ctrl (
	input  wire  logic        aclk,
	input  wire  logic        aresetn,
	input  wire  logic [7:0]  awaddr,
	input  wire  logic        awvalid,
	output logic              awready,
	input  wire  logic [31:0] wdata,
	input  wire  logic [3:0]  wstrb,
	input  wire  logic        wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire  logic        bready,
	input  wire  logic [7:0]  araddr,
	input  wire  logic        arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire  logic        rready,
	input  wire  logic        cfg_reset_pin_is_port,
	input  wire  logic        cfg_fetch_done,
	input  wire  logic [7:0]  port2_pin_in,
	output logic [7:0]        port2_pin_out,
	output logic [7:0]        port2_pin_oe,
	output logic [7:0]        port2_pulldown,
	output logic [7:0]        port2_pullup,
	output logic [3:0]        analog_mode_select_bits,
	input  wire  logic [7:0]  port3_pin_in,
	output logic [7:0]        port3_pin_out,
	output logic [7:0]        port3_pin_oe,
	output logic              ext_reset_req,
	output logic              irq
);
	// ---------------------------------------------------------------
	// Port state
	// ---------------------------------------------------------------
	logic [7:0] latch2_ff, mode2_ff, pullup2_ff, latch3_ff, mode3_ff;
	logic [3:0] analog_ff;
	logic [1:0] mask_ff;
	logic       port_sel_ff;
	logic [1:0] irq_flag;
	logic [1:0] irq_clr;
	logic [7:0] dig2_in, rmw_src, rmw_val;

	// Write handshake.
	logic        aw_ff, w_ff;
	logic [7:0]  awa_ff;
	logic [31:0] wd_ff;
	logic [3:0]  ws_ff;
	logic        wr_go;
	ppc_pkg::ppc_bus_e wst_ff;

	always_comb begin
		dig2_in = port2_pin_in;
		for (int i = 0; i < 4; i++) begin
			if (analog_ff[i])
				dig2_in[i] = 1'b0;
		end
	end

	assign wr_go = aw_ff && w_ff && (wst_ff == ppc_pkg::ST_IDLE);

	always_comb begin
		if (wd_ff[ppc_pkg::BOP_PORT_BIT])
			rmw_src = (port3_pin_in & mode3_ff) | (latch3_ff & ~mode3_ff);
		else
			rmw_src = (dig2_in & mode2_ff) | (latch2_ff & ~mode2_ff);
		rmw_val = rmw_src;
		rmw_val[wd_ff[ppc_pkg::BOP_BIT_LO +: 3]] = wd_ff[ppc_pkg::BOP_SET_BIT];
	end

	// ---------------------------------------------------------------
	// Write channel
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff  <= 1'b0;
			w_ff   <= 1'b0;
			awa_ff <= 8'h00;
			wd_ff  <= 32'h0000_0000;
			ws_ff  <= 4'h0;
			wst_ff <= ppc_pkg::ST_IDLE;
			bvalid <= 1'b0;
			bresp  <= ppc_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_ff  <= 1'b1;
				awa_ff <= awaddr;
			end
			if (wvalid && wready) begin
				w_ff  <= 1'b1;
				wd_ff <= wdata;
				ws_ff <= wstrb;
			end
			if (wr_go) begin
				aw_ff  <= 1'b0;
				w_ff   <= 1'b0;
				wst_ff <= ppc_pkg::ST_RESP;
				bvalid <= 1'b1;
				bresp  <= (awa_ff > ppc_pkg::ADDR_CFG || awa_ff[1:0] != 2'h0)
					? ppc_pkg::RESP_SLVERR : ppc_pkg::RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				wst_ff <= ppc_pkg::ST_IDLE;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !aw_ff && !(awvalid && awready) && (wst_ff == ppc_pkg::ST_IDLE);
			wready  <= !w_ff && !(wvalid && wready) && (wst_ff == ppc_pkg::ST_IDLE);
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch2_ff  <= ppc_pkg::LATCH_RST;
			mode2_ff   <= ppc_pkg::MODE_RST;
			pullup2_ff <= ppc_pkg::LATCH_RST;
			latch3_ff  <= ppc_pkg::LATCH_RST;
			mode3_ff   <= ppc_pkg::MODE_RST;
			analog_ff  <= ppc_pkg::ANALOG_RST;
			mask_ff    <= ppc_pkg::MASK_RST;
		end else if (wr_go && ws_ff[0]) begin
			case (awa_ff)
				ppc_pkg::ADDR_PORT2:    latch2_ff  <= wd_ff[7:0];
				ppc_pkg::ADDR_MODE2:    mode2_ff   <= wd_ff[7:0];
				ppc_pkg::ADDR_ANALOG2:  analog_ff  <= wd_ff[3:0];
				ppc_pkg::ADDR_PULLUP2:  pullup2_ff <= wd_ff[7:0];
				ppc_pkg::ADDR_PORT3:    latch3_ff  <= wd_ff[7:0];
				ppc_pkg::ADDR_MODE3:    mode3_ff   <= wd_ff[7:0];
				ppc_pkg::ADDR_BITOP: begin
					if (wd_ff[ppc_pkg::BOP_PORT_BIT])
						latch3_ff <= rmw_val;
					else
						latch2_ff <= rmw_val;
				end
				ppc_pkg::ADDR_IRQ_MASK: mask_ff    <= wd_ff[1:0];
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Reset pin function
	// ---------------------------------------------------------------
	// latched from config byte
	always_ff @(posedge aclk) begin
		if (!aresetn)
			port_sel_ff <= 1'b0;
		else if (cfg_fetch_done)
			port_sel_ff <= cfg_reset_pin_is_port;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ext_reset_req <= 1'b0;
		else if (!cfg_fetch_done)
			ext_reset_req <= !port3_pin_in[ppc_pkg::PIN_RST_SHR];
		else
			ext_reset_req <= !cfg_reset_pin_is_port && !port3_pin_in[ppc_pkg::PIN_RST_SHR];
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port2_pin_out  <= 8'h00;
			port2_pin_oe   <= 8'h00;
			port2_pullup   <= 8'h00;
			port2_pulldown <= 8'h00;
			port3_pin_out  <= 8'h00;
			port3_pin_oe   <= 8'h00;
			analog_mode_select_bits <= ppc_pkg::ANALOG_RST;
			port2_pulldown[ppc_pkg::PIN_OSC_OUT] <= 1'b1;
			port2_pulldown[ppc_pkg::PIN_OSC_IN]  <= 1'b1;
		end else begin
			port2_pin_out  <= latch2_ff;
			port2_pin_oe   <= ~mode2_ff & {4'h0, ~analog_ff};
			port2_pullup   <= pullup2_ff & mode2_ff;
			port2_pulldown <= 8'h00;
			port3_pin_out  <= latch3_ff;
			port3_pin_oe   <= ~mode3_ff;
			analog_mode_select_bits <= analog_ff;
		end
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	assign irq_clr = (wr_go && ws_ff[0] && awa_ff == ppc_pkg::ADDR_IRQ_STAT) ? wd_ff[1:0] : 2'h0;

	ppc_edge_irq #(.N(2)) u_irq (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_level ({port3_pin_in[ppc_pkg::PIN_IRQ_B], port2_pin_in[ppc_pkg::PIN_IRQ_A]}),
		.clr       (irq_clr),
		.flag_ff   (irq_flag)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_flag & ~mask_ff);
	end

	// ---------------------------------------------------------------
	// Read channel
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= ppc_pkg::RESP_OKAY;
		end else if (rvalid) begin
			if (rready)
				rvalid <= 1'b0;
			arready <= 1'b0;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= ppc_pkg::RESP_OKAY;
			case (araddr)
				ppc_pkg::ADDR_PORT2:    rdata <= {24'h0, (dig2_in & mode2_ff) | (latch2_ff & ~mode2_ff)};
				ppc_pkg::ADDR_MODE2:    rdata <= {24'h0, mode2_ff};
				ppc_pkg::ADDR_ANALOG2:  rdata <= {28'h0, analog_ff};
				ppc_pkg::ADDR_PULLUP2:  rdata <= {24'h0, pullup2_ff};
				ppc_pkg::ADDR_PORT3:    rdata <= {24'h0, (port3_pin_in & mode3_ff) | (latch3_ff & ~mode3_ff)};
				ppc_pkg::ADDR_MODE3:    rdata <= {24'h0, mode3_ff};
				ppc_pkg::ADDR_BITOP:    rdata <= 32'h0000_0000;
				ppc_pkg::ADDR_IRQ_STAT: rdata <= {30'h0, irq_flag};
				ppc_pkg::ADDR_IRQ_MASK: rdata <= {30'h0, mask_ff};
				ppc_pkg::ADDR_CFG:      rdata <= {30'h0, cfg_fetch_done, port_sel_ff};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= ppc_pkg::RESP_SLVERR;
				end
			endcase
		end else begin
			arready <= 1'b1;
		end
	end
endmodule : ppc_port_ctrl
`default_nettype wire

// ---- rtl/ppc_pkg.sv ----
package ppc_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_PORT2    = 8'h00;
	localparam logic [7:0] ADDR_MODE2    = 8'h04;
	localparam logic [7:0] ADDR_ANALOG2  = 8'h08;
	localparam logic [7:0] ADDR_PULLUP2  = 8'h0C;
	localparam logic [7:0] ADDR_PORT3    = 8'h10;
	localparam logic [7:0] ADDR_MODE3    = 8'h14;
	localparam logic [7:0] ADDR_BITOP    = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam logic [7:0] ADDR_CFG      = 8'h24;
	// Reset values.
	localparam logic [7:0] MODE_RST    = 8'hFF;
	localparam logic [7:0] LATCH_RST   = 8'h00;
	localparam logic [3:0] ANALOG_RST  = 4'hF;
	localparam logic [1:0] MASK_RST    = 2'h3;
	// Pin positions.
	localparam int PIN_IRQ_A    = 1;
	localparam int PIN_OSC_OUT  = 2;
	localparam int PIN_OSC_IN   = 3;
	localparam int PIN_IRQ_B    = 2;
	localparam int PIN_RST_SHR  = 4;
	// Bit operation word fields.
	localparam int BOP_BIT_LO   = 0;
	localparam int BOP_PORT_BIT = 3;
	localparam int BOP_SET_BIT  = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RESP = 2'h1
	} ppc_bus_e;
endpackage : ppc_pkg

// ---- rtl/ppc_edge_irq.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_edge_irq #(
	parameter int N = 2
) (
	input  wire  logic         aclk,
	input  wire  logic         aresetn,
	input  wire  logic [N-1:0] pin_level,
	input  wire  logic [N-1:0] clr,
	output logic       [N-1:0] flag_ff
);
	logic [N-1:0] last_ff;
	// The first cycle after reset only loads the pin level, so no false edge follows reset.
	logic [N-1:0] armed_ff;

	for (genvar i = 0; i < N; i++) begin : g_ch
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				last_ff[i]  <= 1'b0;
				armed_ff[i] <= 1'b0;
				flag_ff[i]  <= 1'b0;
			end else begin
				last_ff[i]  <= pin_level[i];
				armed_ff[i] <= 1'b1;
				// Set wins over a clear in the same cycle.
				if (armed_ff[i] && last_ff[i] != pin_level[i])
					flag_ff[i] <= 1'b1;
				else if (clr[i])
					flag_ff[i] <= 1'b0;
			end
		end
	end
endmodule : ppc_edge_irq
`default_nettype wire

// ---- verif/ppc_port_ctrl_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_port_ctrl_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        cfg_reset_pin_is_port,
	input wire logic        cfg_fetch_done,
	input wire logic [7:0]  port2_pin_oe,
	input wire logic [7:0]  port2_pulldown,
	input wire logic [3:0]  analog_mode_select_bits,
	input wire logic [7:0]  port3_pin_in,
	input wire logic        ext_reset_req
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_pull_in_reset: assert property (
		disable iff (1'b0) !aresetn |=> port2_pulldown == 8'h0C)
		else $error("oscillator pins not pulled down in reset");
	a_port_no_reset: assert property (
		cfg_fetch_done && cfg_reset_pin_is_port |=> !ext_reset_req)
		else $error("port-mode pin raised a reset");
	a_pin_gives_reset: assert property (
		cfg_fetch_done && !cfg_reset_pin_is_port && !port3_pin_in[4] |=> ext_reset_req)
		else $error("reset-mode pin low gave no reset");
	a_early_low_reset: assert property (
		!cfg_fetch_done && !port3_pin_in[4] |=> ext_reset_req)
		else $error("low pin before fetch gave no reset");
	a_analog_no_drive: assert property (
		(analog_mode_select_bits & $past(analog_mode_select_bits) & port2_pin_oe[3:0]) == 4'h0)
		else $error("analog pin still driven");
	a_bresp_holds: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (
		arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
endmodule // ppc_port_ctrl_monitor
bind ppc_port_ctrl ppc_port_ctrl_monitor u_ppc_port_ctrl_monitor (.aclk, .aresetn, .bresp,
	.bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .cfg_reset_pin_is_port,
	.cfg_fetch_done, .port2_pin_oe, .port2_pulldown, .analog_mode_select_bits,
	.port3_pin_in, .ext_reset_req);
`default_nettype wire

// ---- verif/ppc_board.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_board (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pull_up,
	input wire logic [7:0] pull_dn,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic     [7:0] pin_in
);
	// A floating pin without pull shows the inverse of its latch, never a stale level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_up | (~pull_dn & ~pin_out)));
endmodule // ppc_board
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        aclk = 1'b0, aresetn = 1'b0, cfg_port = 1'b0, cfg_done = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, p3_ext = 8'hFF;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hF, amode;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, rst_req, irq;
	logic [7:0]  p2_in, p2_out, p2_oe, p2_pd, p2_pu, p3_in, p3_out, p3_oe;
	int          error_cnt = 0, comparisons = 0;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} ppc_row_s;
	ppc_row_s rows [7] = '{'{1'b0, 8'h04, 8'h00, 8'hFF}, '{1'b0, 8'h08, 8'h00, 8'h0F},
		'{1'b0, 8'h20, 8'h00, 8'h03}, '{1'b0, 8'h18, 8'h00, 8'h00},
		'{1'b1, 8'h0C, 8'h00, 8'h00}, '{1'b1, 8'h04, 8'hF0, 8'hF0},
		'{1'b1, 8'h08, 8'h00, 8'h00}};
	ppc_port_ctrl u_ppc_port_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .irq, .cfg_reset_pin_is_port(cfg_port),
		.cfg_fetch_done(cfg_done), .port2_pin_in(p2_in), .port2_pin_out(p2_out),
		.port2_pin_oe(p2_oe), .port2_pulldown(p2_pd), .port2_pullup(p2_pu),
		.analog_mode_select_bits(amode), .port3_pin_in(p3_in), .port3_pin_out(p3_out),
		.port3_pin_oe(p3_oe), .ext_reset_req(rst_req));
	ppc_board u_ppc_board (.pin_out(p2_out), .pin_oe(p2_oe), .pull_up(p2_pu),
		.pull_dn(p2_pd), .ext_val(8'hA0), .ext_en(8'hF0), .pin_in(p2_in));
	ppc_board u_ppc_board_p3 (.pin_out(p3_out), .pin_oe(p3_oe), .pull_up(8'h00),
		.pull_dn(8'h00), .ext_val(p3_ext), .ext_en(8'hFF), .pin_in(p3_in));
	initial forever #5 aclk = ~aclk;
	task complete_run;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task tmo(input int i);
		if (i >= 40) begin
			error_cnt++;
			complete_run;
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		i = 0;
		do begin
			@(posedge aclk);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
			bready <= !bvalid;
			i++;
		end while (!(bvalid && bready) && i < 40);
		r = bresp;
		tmo(i);
	endtask
	task axr(input logic [7:0] a, output logic [31:0] d);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		i = 0;
		do begin
			@(posedge aclk);
			arvalid <= arvalid && !arready;
			rready <= !rvalid;
			i++;
		end while (!(rvalid && rready) && i < 40);
		d = rdata;
		r = rresp;
		tmo(i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d);
		chk("bresp", 32'(r), 32'(ppc_pkg::RESP_OKAY));
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] d;
		axr(a, d);
		chk("rdata", 32'(d[7:0]), 32'(e));
		chk("rresp", 32'(r), 32'(ppc_pkg::RESP_OKAY));
	endtask
	initial begin
		tick(5);
		chk("pulldown", 32'(p2_pd), 32'h0C);
		tick(1);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			if (rows[k].w)
				wr(rows[k].a, 32'(rows[k].d));
			rd(rows[k].a, rows[k].e);
		end
		wr(8'h08, 32'h01);
		tick(2);
		chk("oe", 32'(p2_oe), 32'h0E);
		// Mask both pin events before driving them as outputs.
		wr(8'h20, 32'h03);
		wr(8'h14, 32'hFB);
		wr(8'h1C, 32'h03);
		wr(8'h00, 32'h02);
		wr(8'h10, 32'h04);
		tick(4);
		chk("irq", 32'(irq), 32'h0);
		rd(8'h1C, 8'h03);
		wr(8'h20, 32'h02);
		tick(3);
		chk("irq", 32'(irq), 32'h1);
		wr(8'h1C, 32'h01);
		tick(3);
		chk("irq", 32'(irq), 32'h0);
		wr(8'h18, 32'h10);
		rd(8'h00, 8'hA3);
		wr(8'h18, 32'h0A);
		rd(8'h10, 8'hFB);
		axw(8'h28, 32'h05);
		chk("bresp", 32'(r), 32'(ppc_pkg::RESP_SLVERR));
		p3_ext <= 8'hEF;
		tick(2);
		chk("rst", 32'(rst_req), 32'h1);
		cfg_done <= 1'b1;
		cfg_port <= 1'b1;
		tick(2);
		chk("rst", 32'(rst_req), 32'h0);
		cfg_port <= 1'b0;
		tick(2);
		chk("rst", 32'(rst_req), 32'h1);
		rd(8'h24, 8'h02);
		aresetn <= 1'b0;
		tick(2);
		chk("pulldown", 32'(p2_pd), 32'h0C);
		chk("oe", 32'(p2_oe), 32'h00);
		aresetn <= 1'b1;
		tick(2);
		chk("pulldown", 32'(p2_pd), 32'h00);
		rd(8'h1C, 8'h00);
		complete_run;
	end
endmodule // tb
`default_nettype wire
